// file: rtl/tlic_pkg.sv
package tlic_pkg;
  localparam int TLIC_AW = 8;
  localparam int TLIC_DW = 32;
  // register offsets (byte addresses)
  localparam logic [7:0] TLIC_STATUS_ONE_OFS = 8'h00;
  localparam logic [7:0] TLIC_MASK_ONE_OFS = 8'h04;
  localparam logic [7:0] TLIC_STATUS_TWO_OFS = 8'h08;
  localparam logic [7:0] TLIC_MASK_TWO_OFS = 8'h0C;
  localparam logic [7:0] TLIC_STATUS_THREE_OFS = 8'h10;
  localparam logic [7:0] TLIC_MASK_THREE_OFS = 8'h14;
  localparam logic [7:0] TLIC_EOI_OFS = 8'h18;
  // end-of-interrupt command word: bit positions of latched sources
  localparam int TLIC_EOI_BATTERY = 0;
  localparam int TLIC_EOI_MEDIA = 1;
  localparam int TLIC_EOI_WATCHDOG = 2;
  localparam int TLIC_EOI_TIMER_ONE = 3;
  localparam int TLIC_EOI_TIMER_TWO = 4;
  localparam int TLIC_EOI_CLOCK = 5;
  localparam int TLIC_EOI_MODEM = 6;
  localparam int TLIC_EOI_CODEC = 7;
  localparam int TLIC_EOI_KEY = 8;
  localparam int TLIC_EOI_SERIAL_TWO = 9;
  localparam int TLIC_NUM_LATCHED = 10;
  // status bit positions, bank one
  localparam int TLIC_B1_EXT_FAST = 0;
  localparam int TLIC_B1_BATTERY = 1;
  localparam int TLIC_B1_WATCHDOG = 2;
  localparam int TLIC_B1_MEDIA = 3;
  localparam int TLIC_B1_CODEC = 4;
  localparam int TLIC_B1_EXT_ONE = 5;
  localparam int TLIC_B1_EXT_TWO = 6;
  localparam int TLIC_B1_EXT_THREE = 7;
  localparam int TLIC_B1_TIMER_ONE = 8;
  localparam int TLIC_B1_TIMER_TWO = 9;
  localparam int TLIC_B1_CLOCK = 10;
  localparam int TLIC_B1_TICK = 11;
  localparam int TLIC_B1_UART_TX = 12;
  localparam int TLIC_B1_UART_RX = 13;
  localparam int TLIC_B1_MODEM = 14;
  localparam int TLIC_B1_SERIAL_DONE = 15;
  // bank two and three
  localparam int TLIC_B2_KEY = 0;
  localparam int TLIC_B2_SER_RX = 1;
  localparam int TLIC_B2_SER_TX = 2;
  localparam int TLIC_B2_UART_TX = 12;
  localparam int TLIC_B2_UART_RX = 13;
  localparam int TLIC_B3_AUDIO = 0;
  // fast-type positions and implemented positions per bank
  localparam logic [31:0] TLIC_FAST_ONE = 32'h0000_000F;
  localparam logic [31:0] TLIC_FAST_TWO = 32'h0000_0000;
  localparam logic [31:0] TLIC_FAST_THREE = 32'h0000_0001;
  localparam logic [31:0] TLIC_USED_ONE = 32'h0000_FFFF;
  localparam logic [31:0] TLIC_USED_TWO = 32'h0000_3007;
  localparam logic [31:0] TLIC_USED_THREE = 32'h0000_0001;
  localparam logic [31:0] TLIC_MASK_RESET = 32'h0000_0000;
  // synchroniser reset: pins inactive, external supply present, battery good
  localparam logic [6:0] TLIC_PIN_RESET = 7'h27;
endpackage : tlic_pkg

// file: rtl/tlic_req_if.sv
`timescale 1ns/1ps
// status and mask of all three banks, shared between the request combiner and the top
interface tlic_req_if;
  logic [31:0] status [3];
  logic [31:0] mask [3];
  logic fast_req;
  logic normal_req;
  modport top (output status, output mask, input fast_req, input normal_req);
  modport comb (input status, input mask, output fast_req, output normal_req);
endinterface : tlic_req_if

// file: rtl/tlic_req_combine.sv
`timescale 1ns/1ps
module tlic_req_combine
  import tlic_pkg::*;
(
  tlic_req_if.comb req
);
  wire [31:0] live_one = req.status[0] & req.mask[0] & TLIC_USED_ONE;
  wire [31:0] live_two = req.status[1] & req.mask[1] & TLIC_USED_TWO;
  wire [31:0] live_three = req.status[2] & req.mask[2] & TLIC_USED_THREE;
  // same-type ordering is left to software, so a plain OR per type is enough
  assign req.fast_req = |(live_one & TLIC_FAST_ONE) | |(live_two & TLIC_FAST_TWO)
    | |(live_three & TLIC_FAST_THREE);
  assign req.normal_req = |(live_one & ~TLIC_FAST_ONE) | |(live_two & ~TLIC_FAST_TWO)
    | |(live_three & ~TLIC_FAST_THREE);
endmodule : tlic_req_combine

// file: rtl/tlic_top.sv
`timescale 1ns/1ps
// What this block does
// - after service software writes end-of-interrupt; that latched status bit clears unless its source is still active in that cycle.
// - seventeen sources drive the normal request, five drive the fast request.
// - fast request outranks normal; ordering within one type is left to software.
// - simultaneous requests all stay pending until each is serviced.
// - every input is level-sensitive; requests of non-latched sources follow the present source level.
// - a source reaches a request output only while its mask bit is one.
// - each status bit reads one while its source is active.
// - end-of-interrupt sources are latched until their end-of-interrupt write.
// - bank one bits 0-3 are fast: pin, battery low, watchdog, media change.
// - bank one bits 4-7 normal: codec, external one, two (low), three (high).
// - bank one bits 8-11 normal: timer one, timer two, clock match, 64 Hz tick.
// - bank one bits 12-15 normal: uart one tx, rx, modem, serial one done.
// - bank two: key, serial two rx, tx at 0-2; uart two tx, rx at 12-13.
// - bank three bit 0 is the audio interface request, fast type.
// - status registers are read-only; unused bits read zero.
// - battery low only without external supply and battery-good low, never in standby.
module tlic_top
  import tlic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [tlic_pkg::TLIC_AW-1:0] reg_addr,
  input wire logic [tlic_pkg::TLIC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tlic_pkg::TLIC_DW-1:0] reg_rdata,
  input wire logic external_fast_pin_n,
  input wire logic external_pin_one_n,
  input wire logic external_pin_two_n,
  input wire logic external_pin_three,
  input wire logic external_power_n,
  input wire logic battery_good,
  input wire logic standby,
  input wire logic tick_watchdog_expired,
  input wire logic media_changed_request,
  input wire logic codec_sound_request,
  input wire logic timer_one_underflow,
  input wire logic timer_two_underflow,
  input wire logic clock_match_request,
  input wire logic periodic_tick_request,
  input wire logic uart_one_tx_empty,
  input wire logic uart_one_rx_full,
  input wire logic uart_one_modem_change,
  input wire logic serial_one_transfer_done,
  input wire logic key_press_request,
  input wire logic serial_two_rx_block,
  input wire logic serial_two_tx_block,
  input wire logic uart_two_tx_empty,
  input wire logic uart_two_rx_full,
  input wire logic audio_interface_request,
  output logic fast_request_n,
  output logic normal_request_n
);
  import tlic_pkg::*;

  // pins come from outside the clock domain: two flops before any use
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  wire [6:0] pin_raw = {standby, battery_good, external_power_n, external_pin_three,
    external_pin_two_n, external_pin_one_n, external_fast_pin_n};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_meta_q <= TLIC_PIN_RESET;
      pin_sync_q <= TLIC_PIN_RESET;
    end else if (clk_en) begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire ext_fast = ~pin_sync_q[0];
  wire ext_one = ~pin_sync_q[1];
  wire ext_two = ~pin_sync_q[2];
  wire ext_three = pin_sync_q[3];
  wire no_ext_power = pin_sync_q[4];
  wire battery_ok = pin_sync_q[5];
  wire in_standby = pin_sync_q[6];
  wire battery_low_request = no_ext_power & ~battery_ok & ~in_standby;

  // latched sources: a source edge-independent level sets, end-of-interrupt clears
  logic [TLIC_NUM_LATCHED-1:0] latch_q;
  logic [TLIC_NUM_LATCHED-1:0] latch_d;
  wire [TLIC_NUM_LATCHED-1:0] latch_src = {
    serial_two_rx_block, key_press_request, codec_sound_request, uart_one_modem_change,
    clock_match_request, timer_two_underflow, timer_one_underflow, tick_watchdog_expired,
    media_changed_request, battery_low_request};
  wire eoi_write = reg_wr && (reg_addr == TLIC_EOI_OFS);
  wire [TLIC_NUM_LATCHED-1:0] eoi_clear =
    eoi_write ? reg_wdata[TLIC_NUM_LATCHED-1:0] : '0;

  // a source still active in the clearing cycle sets again: set wins over clear
  assign latch_d = (latch_q & ~eoi_clear) | latch_src;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      latch_q <= '0;
    end else if (clk_en) begin
      latch_q <= latch_d;
    end
  end

  // status words: level sources read live, latched ones read the latch
  wire [31:0] status_one = {16'h0000,
    serial_one_transfer_done, latch_q[TLIC_EOI_MODEM], uart_one_rx_full, uart_one_tx_empty,
    periodic_tick_request, latch_q[TLIC_EOI_CLOCK], latch_q[TLIC_EOI_TIMER_TWO],
    latch_q[TLIC_EOI_TIMER_ONE], ext_three, ext_two, ext_one, latch_q[TLIC_EOI_CODEC],
    latch_q[TLIC_EOI_MEDIA], latch_q[TLIC_EOI_WATCHDOG], latch_q[TLIC_EOI_BATTERY],
    ext_fast};
  wire [31:0] status_two = {18'h0, uart_two_rx_full, uart_two_tx_empty, 9'h0,
    serial_two_tx_block, latch_q[TLIC_EOI_SERIAL_TWO], latch_q[TLIC_EOI_KEY]};
  wire [31:0] status_three = {31'h0, audio_interface_request};

  logic [31:0] mask_one_q;
  logic [31:0] mask_two_q;
  logic [31:0] mask_three_q;
  wire wr_mask_one = reg_wr && (reg_addr == TLIC_MASK_ONE_OFS);
  wire wr_mask_two = reg_wr && (reg_addr == TLIC_MASK_TWO_OFS);
  wire wr_mask_three = reg_wr && (reg_addr == TLIC_MASK_THREE_OFS);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_one_q <= TLIC_MASK_RESET;
      mask_two_q <= TLIC_MASK_RESET;
      mask_three_q <= TLIC_MASK_RESET;
    end else if (clk_en) begin
      if (wr_mask_one) mask_one_q <= reg_wdata;
      if (wr_mask_two) mask_two_q <= reg_wdata;
      if (wr_mask_three) mask_three_q <= reg_wdata;
    end
  end

  tlic_req_if req_bus ();
  assign req_bus.status[0] = status_one;
  assign req_bus.status[1] = status_two;
  assign req_bus.status[2] = status_three;
  assign req_bus.mask[0] = mask_one_q;
  assign req_bus.mask[1] = mask_two_q;
  assign req_bus.mask[2] = mask_three_q;

  tlic_req_combine u_combine (
    .req(req_bus.comb)
  );

  // status writes are ignored; unmapped reads answer zero
  wire [31:0] rd_mux =
    (reg_addr == TLIC_STATUS_ONE_OFS) ? status_one :
    (reg_addr == TLIC_MASK_ONE_OFS) ? mask_one_q :
    (reg_addr == TLIC_STATUS_TWO_OFS) ? status_two :
    (reg_addr == TLIC_MASK_TWO_OFS) ? mask_two_q :
    (reg_addr == TLIC_STATUS_THREE_OFS) ? status_three :
    (reg_addr == TLIC_MASK_THREE_OFS) ? mask_three_q :
    32'h0000_0000;

  // outputs active low, as the core samples a low level; both may be low together,
  // and the core gives the fast one precedence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      fast_request_n <= 1'b1;
      normal_request_n <= 1'b1;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      fast_request_n <= ~req_bus.fast_req;
      normal_request_n <= ~req_bus.normal_req;
    end
  end
endmodule : tlic_top

// file: bench/tlic_monitor.sv
`timescale 1ns/1ps
module tlic_monitor
  import tlic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic external_fast_pin_n,
  input wire logic timer_one_underflow,
  input wire logic uart_one_tx_empty,
  input wire logic audio_interface_request,
  input wire logic fast_request_n,
  input wire logic normal_request_n
);
  logic [31:0] m_q [3];
  logic only_t1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  // mask shadow so requests can be tied to their enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst) m_q <= '{default: 32'h0};
    else if (clk_en && reg_wr && reg_addr[2] && reg_addr < 8'h18)
      m_q[reg_addr[4:3]] <= reg_wdata;
  end
  assign only_t1 = m_q[0] == 32'h100 && m_q[1] == 32'h0 && m_q[2] == 32'h0;
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_mask_read: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == m_q[0])
    else $error("mask readback wrong");
  chk_gaps_zero: assert property (
    reg_rd && reg_addr == 8'h08 |=> (reg_rdata & 32'hFFFF_CFF8) == 32'h0)
    else $error("unassigned status bit set");
  chk_quiet_masked: assert property (
    (m_q[0] == 32'h0 && m_q[1] == 32'h0 && m_q[2] == 32'h0) [*2]
    |-> fast_request_n && normal_request_n)
    else $error("request while all masked");
  chk_audio_fast: assert property (
    audio_interface_request && m_q[2][0] |=> !fast_request_n)
    else $error("audio source missed fast request");
  chk_level_normal: assert property (
    uart_one_tx_empty && m_q[0][12] |=> !normal_request_n)
    else $error("level source missed normal request");
  chk_latch_hold: assert property (
    only_t1 && timer_one_underflow ##1 !reg_wr [*3] |=> !normal_request_n)
    else $error("latched request lost");
  chk_eoi_clears: assert property (
    reg_wr && reg_addr == 8'h18 && reg_wdata[3] && !timer_one_underflow && only_t1
    |=> ##1 normal_request_n)
    else $error("end of interrupt did not clear");
  chk_pin_fast: assert property (
    (!external_fast_pin_n && m_q[0][0]) [*4] |=> !fast_request_n)
    else $error("fast pin missed fast request");
  cov_both: cover property (!fast_request_n && !normal_request_n);
  cov_eoi: cover property (reg_wr && reg_addr == 8'h18);
  cov_fall: cover property ($fell(normal_request_n));
endmodule : tlic_monitor
bind tlic_top tlic_monitor mon_u (.*);

// file: bench/tlic_core_model.sv
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic fast_request_n,
  input wire logic normal_request_n,
  output logic [7:0] vector
);
  // fast outranks normal; taken at the fixed vectors
  assign vector = !fast_request_n ? 8'h1C : (!normal_request_n ? 8'h18 : 8'h00);
endmodule : tlic_core_model

// file: bench/tlic_tb.sv
`timescale 1ns/1ps
module tlic_tb;
  import tlic_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata, rd_q;
  logic fast_request_n, normal_request_n;
  logic [7:0] vector;
  logic [95:0] src = 0;
  logic [95:0] msk = 0;
  logic clk_en = 1'b1;
  logic external_power_n = 1'b1;
  logic standby = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  int p;
  int pos[10] = '{1, 3, 2, 8, 9, 10, 14, 4, 32, 33};
  localparam logic [95:0] NONLAT = 96'h1_0000_3004_0000_B8E1;
  localparam logic [95:0] FAST = {TLIC_FAST_THREE, TLIC_FAST_TWO, TLIC_FAST_ONE};
  always #5 sys_clk = ~sys_clk;
  // clk_en, standby and external_power_n reach the block by name through .*
  tlic_top dut_u (.*, .external_fast_pin_n(!src[0]), .external_pin_one_n(!src[5]),
    .external_pin_two_n(!src[6]), .external_pin_three(src[7]),
    .battery_good(!src[1]), .tick_watchdog_expired(src[2]),
    .media_changed_request(src[3]), .codec_sound_request(src[4]), .timer_one_underflow(src[8]),
    .timer_two_underflow(src[9]), .clock_match_request(src[10]), .periodic_tick_request(src[11]),
    .uart_one_tx_empty(src[12]), .uart_one_rx_full(src[13]), .uart_one_modem_change(src[14]),
    .serial_one_transfer_done(src[15]), .key_press_request(src[32]),
    .serial_two_rx_block(src[33]), .serial_two_tx_block(src[34]), .uart_two_tx_empty(src[44]),
    .uart_two_rx_full(src[45]), .audio_interface_request(src[64]));
  tlic_core_model core_u (.*);
  function automatic logic [7:0] exp_vec(input logic [95:0] s, input logic [95:0] m);
    return |(s & m & FAST) ? 8'h1C : (|(s & m) ? 8'h18 : 8'h00);
  endfunction : exp_vec
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t vector got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd
  task automatic set_masks(input logic [95:0] m);
    msk = m;
    for (int i = 0; i < 3; i++) wr(8'(8 * i + 4), m[32 * i +: 32]);
  endtask : set_masks
  task automatic chk_all(input logic [95:0] e);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      chk(rd_q, i % 2 ? msk[32 * (i / 2) +: 32] : e[32 * (i / 2) +: 32]);
    end
    chk_vec(vector, exp_vec(e, msk));
  endtask : chk_all
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #100us;
    fail_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hA374));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h1C);
    chk(rd_q, 32'h0);
    wr(TLIC_STATUS_ONE_OFS, 32'hFFFF_FFFF);
    chk_all(96'h0);
    $display("reset and map test done");
    for (int n = 0; n < 24; n++) begin
      @(posedge sys_clk);
      // sources hold their level until checked, then the next draw replaces them
      src <= {$urandom(), $urandom(), $urandom()} & NONLAT;
      set_masks({$urandom(), $urandom(), $urandom()});
      chk_all(src);
    end
    $display("level source test done");
    for (int k = 0; k < 10; k++) begin
      p = pos[k];
      set_masks(96'h1 << p);
      src <= 96'h1 << p;
      repeat (4) @(posedge sys_clk);
      chk_all(96'h1 << p);
      wr(TLIC_EOI_OFS, 32'h1 << k);
      chk_all(96'h1 << p);
      @(posedge sys_clk);
      src <= 96'h0;
      repeat (3) @(posedge sys_clk);
      chk_all(96'h1 << p);
      wr(TLIC_EOI_OFS, 32'h1 << k);
      chk_all(96'h0);
    end
    $display("latched source test done");
    // battery-good low must not raise battery low in standby or on external supply
    set_masks(96'h2);
    standby <= 1'b1;
    src <= 96'h2;
    repeat (4) @(posedge sys_clk);
    chk_all(96'h0);
    @(posedge sys_clk);
    standby <= 1'b0;
    external_power_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_all(96'h0);
    @(posedge sys_clk);
    src <= 96'h0;
    external_power_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    $display("battery qualifier test done");
    // a write while clk_en is low must leave the mask untouched
    clk_en <= 1'b0;
    wr(TLIC_MASK_ONE_OFS, 32'h0000_5A5A);
    clk_en <= 1'b1;
    chk_all(96'h0);
    $display("clock enable test done");
    set_masks(96'h100);
    src <= 96'h100;
    repeat (3) @(posedge sys_clk);
    src <= 96'h0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    msk = 96'h0;
    chk_all(96'h0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : tlic_tb
